/* gyro_fmt_asserts.sv */
// Concurrent checks on the gyro field formatter ports
`timescale 1ns/1ps
`default_nettype none
module gyro_fmt_asserts #(
  parameter AXES = 3,
  parameter CW   = 10
) (
  // Clock, reset and controls
  input wire logic              i_ref_clk,
  input wire logic              i_reset,
  input wire logic              i_sample_valid,
  input wire logic [AXES*16-1:0] i_temp_sample,
  input wire logic [1:0]        i_out_unit,
  input wire logic              i_capture,
  // Formatted fields
  input wire logic [AXES*8-1:0] o_rate_byte_high,
  input wire logic [AXES*8-1:0] o_rate_byte_mid,
  input wire logic [AXES*8-1:0] o_rate_byte_low,
  input wire logic [AXES*8-1:0] o_angle_byte_high,
  input wire logic [AXES*8-1:0] o_angle_byte_mid,
  input wire logic [AXES*8-1:0] o_angle_byte_low,
  input wire logic [AXES*8-1:0] o_temp_byte_high,
  input wire logic [AXES*8-1:0] o_temp_byte_low,
  input wire logic [7:0]        o_delay_byte_high,
  input wire logic [7:0]        o_delay_byte_low,
  input wire logic [7:0]        o_sample_count,
  input wire logic              o_fields_valid
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // Capture handshake and field selection
  AST_VALID_AFTER_CAPTURE: assert property (i_capture |=> o_fields_valid)
    else $error("fields not valid after capture");
  AST_VALID_CAUSE: assert property (o_fields_valid |-> $past(i_capture))
    else $error("fields valid without capture");
  // Angle modes have bit 0 set, so the rate group must read zero then
  AST_RATE_ZERO: assert property (o_fields_valid && $past(i_out_unit[0]) |->
    {o_rate_byte_high, o_rate_byte_mid, o_rate_byte_low} == '0)
    else $error("rate bytes set in angle mode");
  AST_ANGLE_ZERO: assert property (o_fields_valid && !$past(i_out_unit[0]) |->
    {o_angle_byte_high, o_angle_byte_mid, o_angle_byte_low} == '0)
    else $error("angle bytes set in rate mode");
  // Fields stand unchanged between captures
  AST_FIELDS_HOLD: assert property (!o_fields_valid |-> $stable({o_rate_byte_high,
    o_rate_byte_mid, o_rate_byte_low, o_angle_byte_high, o_angle_byte_mid, o_angle_byte_low,
    o_temp_byte_high, o_temp_byte_low, o_delay_byte_high, o_delay_byte_low, o_sample_count}))
    else $error("fields changed without capture");
  // Capture three cycles after a sample sees a fresh latency
  AST_DELAY_FRESH: assert property (i_sample_valid ##3 i_capture |=>
    {o_delay_byte_high, o_delay_byte_low} == 16'h0000)
    else $error("latency not restarted by sample");
  AST_RESET_CLEARS: assert property (disable iff (1'b0) i_reset |=>
    !o_fields_valid && o_sample_count == 8'h00 && o_angle_byte_high == '0)
    else $error("outputs not cleared by reset");
  // ==========================================================
  // Temperature per axis, high byte first
  for (genvar a = 0; a < AXES; a++) begin : g_temp
    AST_TEMP_PASS: assert property (o_fields_valid |->
      {o_temp_byte_high[a*8+:8], o_temp_byte_low[a*8+:8]} == $past(i_temp_sample[a*16+:16]))
      else $error("temperature field mismatch");
  end
endmodule
`default_nettype wire

/* gyro_fmt_consts.vh */
// Shared constants for the gyro output value formatter
`ifndef GYRO_FMT_CONSTS_VH
`define GYRO_FMT_CONSTS_VH

// ==========================================================================
// Output unit selection codes
// ==========================================================================
`define UNIT_RATE        2'h0
`define UNIT_INCREMENT   2'h1
`define UNIT_AVERAGE     2'h2
`define UNIT_INTEGRATED  2'h3

// ==========================================================================
// Field widths
// ==========================================================================
`define ANGLE_W          24
`define TEMP_W           16
`define COUNT_W          8
`define DELAY_W          16

// ==========================================================================
// Timing: latency counts whole microseconds at the reference clock
// ==========================================================================
`define CLK_PERIOD_NS    50
`define US_IN_NS         1000
`define US_TICK_CYCLES   (`US_IN_NS / `CLK_PERIOD_NS)
`define SAMPLE_PERIOD_US 1000

// ==========================================================================
// Scaling between rate units (2^-14 deg/s) and angle units (2^-21 deg)
// One rate step times 1 ms equals 128/1000 angle steps, so angle sums
// are kept in thousandths of an angle step.
// ==========================================================================
`define RATE_TO_FINE_SH  7
`define FINE_PER_LSB     1000
`define FINE_HALF        37'h01f4000000
`define FINE_FULL        37'h03e8000000
`define ANGLE_SIGN_FLIP  24'h800000

// ==========================================================================
// Low-pass filter fraction bits
// ==========================================================================
`define LPF_FRAC         8

`endif

/* gyro_host_rx.sv */
// Host receiver model rebuilding signed fields from the bytes
`timescale 1ns/1ps
`default_nettype none
module gyro_host_rx (
  // Formatter side
  input  wire logic        i_ref_clk,
  input  wire logic        i_fields_valid,
  input  wire logic [23:0] i_rh, i_rm, i_rl, i_ah, i_am, i_al, i_th, i_tl,
  input  wire logic [7:0]  i_dh, i_dl,
  // Rebuilt values, sign extended to 32 bits; latency stays 16 bits unsigned
  output var logic signed [31:0] o_rate [3],
  output var logic signed [31:0] o_angle [3],
  output var logic signed [31:0] o_temp [3],
  output var logic [15:0]        o_delay
);
  // Take bytes only on the valid pulse; they stand until the next one
  always @(posedge i_ref_clk) begin
    if (i_fields_valid) begin
      for (int a = 0; a < 3; a++) begin
        o_rate[a]  <= {{8{i_rh[a*8+7]}}, i_rh[a*8+:8], i_rm[a*8+:8], i_rl[a*8+:8]};
        o_angle[a] <= {{8{i_ah[a*8+7]}}, i_ah[a*8+:8], i_am[a*8+:8], i_al[a*8+:8]};
        o_temp[a]  <= {{16{i_th[a*8+7]}}, i_th[a*8+:8], i_tl[a*8+:8]};
      end
      o_delay <= {i_dh, i_dl};
    end
  end
endmodule
`default_nettype wire

/* gyro_lowpass.v */
// First-order low-pass filter for one gyro axis
`timescale 1ns/1ps
`default_nettype none
`include "gyro_fmt_consts.vh"

module gyro_lowpass #(
  parameter W    = 24,
  parameter FRAC = `LPF_FRAC
) (
  // Clock and reset
  input  wire                  i_ref_clk,
  input  wire                  i_reset,
  // Raw sample in
  input  wire                  i_valid,
  input  wire signed [W-1:0]   i_sample,
  input  wire        [2:0]     i_shift,
  // Filtered sample out
  output reg                   o_valid,
  output wire signed [W-1:0]   o_filtered
);

  // ==========================================================================
  // Filter state
  // ==========================================================================
  reg  signed [W+FRAC-1:0] acc_q;   // Filter state with fraction bits
  wire signed [W+FRAC-1:0] x_ext;   // Input aligned to state
  wire signed [W+FRAC:0]   diff;    // One extra bit avoids overflow
  wire signed [W+FRAC:0]   step;    // Scaled correction

  assign x_ext = {i_sample, {FRAC{1'b0}}};
  assign diff  = {x_ext[W+FRAC-1], x_ext} - {acc_q[W+FRAC-1], acc_q};
  assign step  = diff >>> i_shift;
  assign o_filtered = acc_q[W+FRAC-1:FRAC];

  // Update on each raw sample; shift zero bypasses the filter
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      acc_q   <= {(W+FRAC){1'b0}};
      o_valid <= 1'b0;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        if (i_shift == 3'h0) begin
          acc_q <= x_ext;
        end else begin
          acc_q <= acc_q + step[W+FRAC-1:0];
        end
      end
    end
  end

endmodule
`default_nettype wire

/* gyro_output_value_formatter.v */
// Gyro measurement field formatter: rate, angle, temperature, counter, latency
`timescale 1ns/1ps
`default_nettype none
`include "gyro_fmt_consts.vh"

module gyro_output_value_formatter #(
  parameter AXES = 3,
  parameter CW   = 10
) (
  // Clock and reset
  input  wire                  i_ref_clk,
  input  wire                  i_reset,
  // Internal samples, one strobe per millisecond
  input  wire                  i_sample_valid,
  input  wire [AXES*24-1:0]    i_rate_sample,
  input  wire [AXES*3-1:0]     i_lpf_shift,
  input  wire [AXES*16-1:0]    i_temp_sample,
  // Configuration and transmit capture
  input  wire [1:0]            i_out_unit,
  input  wire                  i_capture,
  // Formatted fields
  output wire [AXES*8-1:0]     o_rate_byte_high,
  output wire [AXES*8-1:0]     o_rate_byte_mid,
  output wire [AXES*8-1:0]     o_rate_byte_low,
  output wire [AXES*8-1:0]     o_angle_byte_high,
  output wire [AXES*8-1:0]     o_angle_byte_mid,
  output wire [AXES*8-1:0]     o_angle_byte_low,
  output wire [AXES*8-1:0]     o_temp_byte_high,
  output wire [AXES*8-1:0]     o_temp_byte_low,
  output wire [7:0]            o_delay_byte_high,
  output wire [7:0]            o_delay_byte_low,
  output reg  [7:0]            o_sample_count,
  output reg                   o_fields_valid
);

  // ==========================================================================
  // Local constants
  // ==========================================================================
  localparam [31:0] TICK_LAST_W = `US_TICK_CYCLES - 1; // Last cycle of a microsecond
  localparam [4:0]  TICK_LAST = TICK_LAST_W[4:0];    // Cut to the cycle counter width
  localparam [15:0] DELAY_MAX = 16'hffff;              // Latency saturates here
  localparam [CW-1:0] CNT_MAX = {CW{1'b1}};            // Window count saturates here
  localparam signed [41:0] DIV_INC = 42'sh3e8;         // Fine units per angle step
  localparam [36:0] DIV_INT = 37'h3e8;                 // Same, for the unsigned path

  // ==========================================================================
  // Shared timing state
  // ==========================================================================
  wire [AXES-1:0] filt_valid;     // Filtered sample strobes, one per axis
  wire            fv;             // Common filtered strobe
  reg  [CW-1:0]   win_cnt_q;      // Samples in the current window
  reg  [7:0]      samp_cnt_q;     // Free-running sample counter
  reg  [4:0]      tick_q;         // Cycles within the current microsecond
  reg  [15:0]     lat_q;          // Microseconds since the last filtered sample
  reg  [15:0]     delay_q;        // Latency captured for transmission

  assign fv = &filt_valid; // All axes share one strobe, so every bit agrees

  // Sample counter: one step per filtered sample, wraps at 255
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      samp_cnt_q <= 8'h00;
    end else if (fv) begin
      samp_cnt_q <= samp_cnt_q + 8'h01;
    end
  end

  // Window sample count for the average; restarts with each capture
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      win_cnt_q <= {CW{1'b0}};
    end else if (i_capture) begin
      // A sample landing with the capture opens the next window
      win_cnt_q <= fv ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}};
    end else if (fv && (win_cnt_q != CNT_MAX)) begin
      win_cnt_q <= win_cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Latency timer: restarts when a filtered sample is ready
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      tick_q <= 5'h00;
      lat_q  <= 16'h0000;
    end else if (fv) begin
      tick_q <= 5'h00;
      lat_q  <= 16'h0000;
    end else if (tick_q == TICK_LAST) begin
      tick_q <= 5'h00;
      // Saturate rather than wrap, so a stalled sample path reads as long
      if (lat_q != DELAY_MAX) begin
        lat_q <= lat_q + 16'h0001;
      end
    end else begin
      tick_q <= tick_q + 5'h01;
    end
  end

  // Capture of the shared fields at the transmit moment
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      delay_q        <= 16'h0000;
      o_sample_count <= 8'h00;
      o_fields_valid <= 1'b0;
    end else begin
      o_fields_valid <= i_capture;
      if (i_capture) begin
        delay_q        <= lat_q;
        o_sample_count <= samp_cnt_q;
      end
    end
  end

  // Latency bytes, most significant first
  assign o_delay_byte_high = delay_q[15:8];
  assign o_delay_byte_low  = delay_q[7:0];

  // ==========================================================================
  // Per-axis processing
  // ==========================================================================
  genvar a;
  generate
    for (a = 0; a < AXES; a = a + 1) begin : g_axis
      wire signed [23:0] filt;        // Filtered rate sample
      wire signed [30:0] fine_step;   // Sample times 1 ms, in fine units
      wire signed [36:0] integ_sum;   // Integrator before wrap
      wire signed [36:0] integ_wrap;  // Integrator after wrap
      wire        [36:0] integ_ofs;   // Integrator shifted to non-negative
      wire        [36:0] integ_div;   // Integrated angle plus offset
      wire signed [41:0] inc_div;     // Incremental angle in steps
      wire signed [35:0] avg_div;     // Average rate in rate steps
      reg  signed [23:0] last_q;      // Latest filtered sample
      reg  signed [35:0] avg_sum_q;   // Sum of samples in the window
      reg  signed [41:0] inc_sum_q;   // Sum of fine steps in the window
      reg  signed [36:0] integ_q;     // Continuous integrator, fine units
      reg         [23:0] rate_q;      // Captured rate-group value
      reg         [23:0] angle_q;     // Captured angle-group value
      reg         [15:0] temp_q;      // Captured temperature

      // Filter ahead of every use of the sample
      gyro_lowpass #(
        .W    (24),
        .FRAC (`LPF_FRAC)
      ) u_lpf (
        .i_ref_clk  (i_ref_clk),
        .i_reset    (i_reset),
        .i_valid    (i_sample_valid),
        .i_sample   (i_rate_sample[a*24 +: 24]),
        .i_shift    (i_lpf_shift[a*3 +: 3]),
        .o_valid    (filt_valid[a]),
        .o_filtered (filt)
      );

      // Rate step times 128 gives thousandths of an angle step
      assign fine_step = {filt, {`RATE_TO_FINE_SH{1'b0}}};
      assign integ_sum = integ_q + {{6{fine_step[30]}}, fine_step};

      // One correction suffices: a step is far smaller than the span
      assign integ_wrap = (integ_sum >= $signed(`FINE_HALF)) ? integ_sum - `FINE_FULL :
                          (integ_sum < -$signed(`FINE_HALF)) ? integ_sum + `FINE_FULL :
                          integ_sum;

      // Offset keeps the division unsigned and floor-rounded
      assign integ_ofs = integ_q + `FINE_HALF;
      assign integ_div = integ_ofs / DIV_INT;
      // Truncation toward zero is accepted for the windowed sum
      assign inc_div   = inc_sum_q / DIV_INC;
      assign avg_div   = avg_sum_q / $signed({{(36-CW){1'b0}}, win_cnt_q});

      // Accumulators: window sums restart at capture, integrator only at reset
      always @(posedge i_ref_clk) begin
        if (i_reset) begin
          last_q    <= 24'h000000;
          avg_sum_q <= 36'h000000000;
          inc_sum_q <= 42'h00000000000;
          integ_q   <= 37'h0000000000;
        end else begin
          if (fv) begin
            last_q  <= filt;
            integ_q <= integ_wrap;
          end
          if (i_capture) begin
            // Sample in the capture cycle belongs to the new window
            avg_sum_q <= fv ? {{12{filt[23]}}, filt} : 36'h000000000;
            inc_sum_q <= fv ? {{11{fine_step[30]}}, fine_step} : 42'h00000000000;
          end else if (fv) begin
            avg_sum_q <= avg_sum_q + {{12{filt[23]}}, filt};
            inc_sum_q <= inc_sum_q + {{11{fine_step[30]}}, fine_step};
          end
        end
      end

      // Capture of the per-axis fields by output unit
      always @(posedge i_ref_clk) begin
        if (i_reset) begin
          rate_q  <= 24'h000000;
          angle_q <= 24'h000000;
          temp_q  <= 16'h0000;
        end else if (i_capture) begin
          temp_q <= i_temp_sample[a*16 +: 16];
          case (i_out_unit)
            `UNIT_RATE: begin
              rate_q  <= last_q;
              angle_q <= 24'h000000;
            end
            `UNIT_AVERAGE: begin
              // An empty window repeats the latest sample
              if (win_cnt_q == {CW{1'b0}}) begin
                rate_q <= last_q;
              end else begin
                rate_q <= avg_div[23:0];
              end
              angle_q <= 24'h000000;
            end
            `UNIT_INCREMENT: begin
              rate_q  <= 24'h000000;
              angle_q <= inc_div[23:0];
            end
            `UNIT_INTEGRATED: begin
              rate_q  <= 24'h000000;
              angle_q <= integ_div[23:0] ^ `ANGLE_SIGN_FLIP;
            end
            default: begin
              rate_q  <= 24'h000000;
              angle_q <= 24'h000000;
            end
          endcase
        end
      end

      // Byte split, most significant byte first
      assign o_rate_byte_high[a*8 +: 8]  = rate_q[23:16];
      assign o_rate_byte_mid[a*8 +: 8]   = rate_q[15:8];
      assign o_rate_byte_low[a*8 +: 8]   = rate_q[7:0];
      assign o_angle_byte_high[a*8 +: 8] = angle_q[23:16];
      assign o_angle_byte_mid[a*8 +: 8]  = angle_q[15:8];
      assign o_angle_byte_low[a*8 +: 8]  = angle_q[7:0];
      assign o_temp_byte_high[a*8 +: 8]  = temp_q[15:8];
      assign o_temp_byte_low[a*8 +: 8]   = temp_q[7:0];
    end
  endgenerate

endmodule
`default_nettype wire

/* gyro_output_value_formatter_test.sv */
// Self-checking bench for the gyro field formatter
`timescale 1ns/1ps
`default_nettype none
module gyro_output_value_formatter_test;
  // ==========================================================
  // Stimulus and observed signals
  logic              i_ref_clk = 0, i_reset = 1, i_sample_valid = 0, i_capture = 0;
  logic [71:0]       i_rate_sample = '0;
  logic [8:0]        i_lpf_shift = '0;
  logic [47:0]       i_temp_sample = '0;
  logic [1:0]        i_out_unit = '0;
  wire logic [23:0]  rh, rm, rl, ah, am, al, th, tl;
  wire logic [7:0]   dh, dl, cnt;
  wire logic         fv;
  logic signed [31:0] hr [3], ha [3], ht [3];
  logic [15:0]       hd;
  // Reference model state: filter, window sums, integrator
  longint            yq [3] = '{0, 0, 0}, sum [3] = '{0, 0, 0}, integ [3] = '{0, 0, 0};
  longint            last [3] = '{0, 0, 0};
  int                nwin = 0, nsamp = 0, err_count = 0, cmp_count = 0, r, i, n;
  logic [31:0]       lf = 32'h00000042;

  gyro_output_value_formatter #(.AXES(3), .CW(10)) u_dut (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_sample_valid(i_sample_valid),
    .i_rate_sample(i_rate_sample), .i_lpf_shift(i_lpf_shift), .i_temp_sample(i_temp_sample),
    .i_out_unit(i_out_unit), .i_capture(i_capture), .o_rate_byte_high(rh),
    .o_rate_byte_mid(rm), .o_rate_byte_low(rl), .o_angle_byte_high(ah), .o_angle_byte_mid(am),
    .o_angle_byte_low(al), .o_temp_byte_high(th), .o_temp_byte_low(tl),
    .o_delay_byte_high(dh), .o_delay_byte_low(dl), .o_sample_count(cnt), .o_fields_valid(fv));
  gyro_host_rx u_host (
    .i_ref_clk(i_ref_clk), .i_fields_valid(fv), .i_rh(rh), .i_rm(rm), .i_rl(rl), .i_ah(ah),
    .i_am(am), .i_al(al), .i_th(th), .i_tl(tl), .i_dh(dh), .i_dl(dl), .o_rate(hr),
    .o_angle(ha), .o_temp(ht), .o_delay(hd));

  initial forever #25 i_ref_clk = ~i_ref_clk;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Random rate kept to 23 bits so the filter path never overflows
  function automatic longint rnd();
    lf = lfsr_next(lf);
    return longint'($signed(lf[22:0]));
  endfunction
  function automatic logic [31:0] sx(input longint v, input int w);
    return (w == 24) ? {{8{v[23]}}, v[23:0]} : {{16{v[15]}}, v[15:0]};
  endfunction
  // Floor division by 1000, as the integrator rounds down
  function automatic longint fl(input longint x);
    return (x >= 0) ? x / 1000 : -((-x + 999) / 1000);
  endfunction
  function automatic longint exp_rate(input int a, input logic [1:0] u);
    if (u == 2'h0) return last[a];
    if (u == 2'h2) return (nwin != 0) ? sum[a] / nwin : last[a];
    return 0;
  endfunction
  function automatic longint exp_angle(input int a, input logic [1:0] u);
    if (u == 2'h1) return sum[a] * 128 / 1000;
    if (u == 2'h3) return fl(integ[a] * 128);
    return 0;
  endfunction
  task automatic tick();
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One internal sample; ends once the design has folded it in
  task automatic sample(input longint v0, input longint v1, input longint v2);
    longint v [3];
    v = '{v0, v1, v2};
    for (int a = 0; a < 3; a++) i_rate_sample[a*24+:24] = v[a][23:0];
    i_sample_valid = 1;
    tick();
    i_sample_valid = 0;
    tick();
    tick();
    for (int a = 0; a < 3; a++) begin
      yq[a] += ((v[a] <<< 8) - yq[a]) >>> i_lpf_shift[a*3+:3];
      last[a] = yq[a] >>> 8;
      sum[a] += last[a];
      integ[a] += last[a];
    end
    nwin++;
    nsamp++;
  endtask
  // Capture after w idle cycles; w below zero skips the latency check
  task automatic capture(input logic [1:0] u, input int w);
    i_out_unit = u;
    lf = lfsr_next(lf);
    i_temp_sample = {lf[15:0], lf[31:16], lf[23:8]};
    repeat (w) tick();
    i_capture = 1;
    tick();
    i_capture = 0;
    tick();
    tick();
    for (int a = 0; a < 3; a++) begin
      check(hr[a], sx(exp_rate(a, u), 24));
      check(ha[a], sx(exp_angle(a, u), 24));
      check(ht[a], sx(i_temp_sample[a*16+:16], 16));
      sum[a] = 0;
    end
    check({24'h0, cnt}, nsamp % 256);
    if (w >= 0) check({16'h0, hd}, w / 20);
    nwin = 0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) tick();
    i_reset = 0;
    tick();
    check({dh, dl, cnt}, 32'h0);
    // Filter ahead of averaging, different shift per axis
    i_lpf_shift = 9'h00a;
    sample(1000, 2000, 3000);
    sample(4000, 5000, 6000);
    capture(2'h2, 0);
    i_lpf_shift = 9'h000;
    // Random windows in every unit, empty windows included
    for (r = 0; r < 16; r++) begin
      lf = lfsr_next(lf);
      n = lf % 5;
      for (i = 0; i < n; i++) sample(rnd(), rnd(), rnd());
      capture(r[1:0], (n != 0) ? 0 : -1);
    end
    // Latency grows in whole microseconds
    sample(rnd(), rnd(), rnd());
    capture(2'h0, 70);
    // Counter and integrator both wrap on a long run of full-scale rates, half scale on the third axis
    for (i = 0; i < 260; i++) sample(8388607, -8388608, 4194304);
    capture(2'h3, 0);
    capture(2'h1, -1);
    // Second reset restarts integration and counting
    i_reset = 1;
    tick();
    tick();
    i_reset = 0;
    tick();
    for (i = 0; i < 3; i++) begin
      yq[i] = 0;
      integ[i] = 0;
      sum[i] = 0;
      last[i] = 0;
    end
    nwin = 0;
    nsamp = 0;
    sample(-3000, 777, 5);
    capture(2'h3, 0);
    summarize();
  end

  // Watchdog well beyond the 1129 cycles at most that the run needs
  initial begin
    repeat (30000) @(posedge i_ref_clk);
    err_count++;
    summarize();
  end
endmodule

bind gyro_output_value_formatter gyro_fmt_asserts #(.AXES(AXES), .CW(CW)) u_chk (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_sample_valid(i_sample_valid),
  .i_temp_sample(i_temp_sample), .i_out_unit(i_out_unit), .i_capture(i_capture),
  .o_rate_byte_high(o_rate_byte_high), .o_rate_byte_mid(o_rate_byte_mid),
  .o_rate_byte_low(o_rate_byte_low), .o_angle_byte_high(o_angle_byte_high),
  .o_angle_byte_mid(o_angle_byte_mid), .o_angle_byte_low(o_angle_byte_low),
  .o_temp_byte_high(o_temp_byte_high), .o_temp_byte_low(o_temp_byte_low),
  .o_delay_byte_high(o_delay_byte_high), .o_delay_byte_low(o_delay_byte_low),
  .o_sample_count(o_sample_count), .o_fields_valid(o_fields_valid));
`default_nettype wire
